// >>> logic/pm_defines.svh
// Constants for the power mode controller
`ifndef PM_DEFINES_SVH
`define PM_DEFINES_SVH
`define PM_AW 4
`define PM_DW 8
`define PM_IO_W 8
`define PM_CNT_W 8
// Register offsets
`define PM_OFS_PMC 4'h0
`define PM_OFS_SLEEP 4'h1
`define PM_OFS_CLK 4'h2
`define PM_OFS_STAT 4'h3
// Field positions
`define PM_IDLE_BIT 0
`define PM_MODE_MSB 1
`define PM_MODE_LSB 0
`define PM_FRC_STB_BIT 5
`define PM_XTAL_STB_BIT 6
`define PM_USB_BIT 7
`define PM_OSC_BIT 0
`define PM_LSOSC_BIT 7
// Reset values
`define PM_OSC_RST 1'b1
`define PM_LSOSC_RST 1'b0
`define PM_USB_RST 1'b0
// Sequence lengths in cycles
`define PM_PD_LIGHT_CYC 8'h02
`define PM_PD_DEEP_CYC 8'h08
`define PM_PU_LIGHT_CYC 8'h02
`define PM_PU_DEEP_CYC 8'h08
`endif

// >>> logic/pm_pkg.sv
// Types of the power mode controller
package pm_pkg;
  typedef enum logic [2:0] {
    ST_ACTIVE = 3'b000,
    ST_IDLE = 3'b001,
    ST_PDOWN = 3'b010,
    ST_SLEEP = 3'b011,
    ST_PUP = 3'b100
  } pm_state_t;

  typedef enum logic [1:0] {
    SM_NONE = 2'b00,
    SM_LIGHT = 2'b01,
    SM_DEEP = 2'b10,
    SM_OFF = 2'b11
  } sleep_mode_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic crystal_en;
    logic fastrc_en;
    logic lsosc_en;
    logic core_reg_en;
    logic cpu_clk_en;
    logic sysclk_crystal;
  } pwr_ctl_t;

  typedef struct packed {
    pm_state_t st;
    sleep_mode_t mode;
    sleep_mode_t kind;
    logic [7:0] cnt;
    logic usb_en;
    logic usb_rst;
    logic osc_sel;
    logic lsosc_sel;
    logic xtal_was;
    logic frc_was;
    logic [7:0] rdata;
    pwr_ctl_t pwr;
    logic irq_block;
    logic resume;
    logic io_hold;
    logic [7:0] io_dir;
    logic [7:0] io_out;
  } pm_regs_t;
endpackage : pm_pkg

// >>> logic/power_mode_controller.sv
// Power mode controller: active, idle and three sleep modes
`timescale 1ns/1ps
`include "pm_defines.svh"

// Operation
// - One active mode, four low-power modes
// - Active: regulator on, oscillators running
// - Idle trigger without mode gates CPU
// - Any interrupt ends idle, resumes
// - Light sleep: fast oscillators off
// - Deep sleep: regulator off, timer wakes
// - Off mode: all off, port wake only
// - Pins frozen during sleep modes
// - Power-down sequence, light one shorter
// - Interrupt wake resumes, reset restarts
// - Deep and off drop USB state
// - Restart oscillators, fast RC until stable
// - Trigger enters mode selected in field
// - Wakeup clears mode field and trigger
// - Nonzero mode field blocks wake interrupts
// - Mode field cleared at sleep entry
// - Registers other than mode field and USB bit keep values across sleep
// - Idle trigger always reads zero
module power_mode_controller #(
  parameter logic [7:0] PD_LIGHT = `PM_PD_LIGHT_CYC,
  parameter logic [7:0] PD_DEEP = `PM_PD_DEEP_CYC,
  parameter logic [7:0] PU_LIGHT = `PM_PU_LIGHT_CYC,
  parameter logic [7:0] PU_DEEP = `PM_PU_DEEP_CYC
) (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire pm_pkg::reg_req_t REG_REQ,
  output logic [7:0] RDATA,
  input wire logic EXT_IRQ,
  input wire logic TIMER_IRQ,
  input wire logic ANY_IRQ,
  input wire logic CRYSTAL_READY,
  input wire logic FASTRC_READY,
  input wire logic [7:0] IO_DIR_CORE,
  input wire logic [7:0] IO_OUT_CORE,
  output logic [7:0] IO_DIR,
  output logic [7:0] IO_OUT,
  output logic IO_HOLD,
  output logic CPU_CLK_EN,
  output logic CRYSTAL_EN,
  output logic FASTRC_EN,
  output logic LSOSC_EN,
  output logic CORE_REG_EN,
  output logic SYSCLK_CRYSTAL,
  output logic USB_RST,
  output logic IRQ_BLOCK,
  output logic RESUME,
  output logic [2:0] POWER_STATE
);

  localparam int PD_MAXI = 12;
  localparam int PU_MAXI = 12;

  pm_pkg::pm_regs_t q;
  pm_pkg::pm_regs_t d;
  logic idle_wr;
  logic wake;
  logic sleeping;

  // Deep and off share the long sequence
  function automatic logic is_deep(input pm_pkg::sleep_mode_t k);
    is_deep = (k == pm_pkg::SM_DEEP) || (k == pm_pkg::SM_OFF);
  endfunction : is_deep

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d = q;
    d.resume = 1'b0;
    d.rdata = 8'h00;
    idle_wr = REG_REQ.wr && (REG_REQ.addr == `PM_OFS_PMC) &&
              REG_REQ.wdata[`PM_IDLE_BIT];
    wake = EXT_IRQ || (TIMER_IRQ && (q.kind != pm_pkg::SM_OFF));
    if (REG_REQ.wr) begin
      case (REG_REQ.addr)
        `PM_OFS_SLEEP: begin
          d.mode = pm_pkg::sleep_mode_t'(
            REG_REQ.wdata[`PM_MODE_MSB:`PM_MODE_LSB]);
          d.usb_en = REG_REQ.wdata[`PM_USB_BIT];
        end
        `PM_OFS_CLK: begin
          d.osc_sel = REG_REQ.wdata[`PM_OSC_BIT];
          d.lsosc_sel = REG_REQ.wdata[`PM_LSOSC_BIT];
        end
        default: begin
        end
      endcase
    end
    // One active state, four low-power kinds
    case (q.st)
      pm_pkg::ST_ACTIVE: begin
        if (idle_wr) begin
          // No mode selected: CPU idle only
          if (q.mode == pm_pkg::SM_NONE) begin
            d.st = pm_pkg::ST_IDLE;
          end else begin
            // Enter mode held in the field
            d.st = pm_pkg::ST_PDOWN;
            d.kind = q.mode;
            d.cnt = is_deep(q.mode) ? PD_DEEP : PD_LIGHT;
            d.xtal_was = q.pwr.crystal_en;
            d.frc_was = q.pwr.fastrc_en;
            d.io_hold = 1'b1;
            // USB state lost in deep and off
            if (is_deep(q.mode)) begin
              d.usb_en = 1'b0;
            end
          end
        end
      end
      pm_pkg::ST_IDLE: begin
        if (ANY_IRQ) begin
          d.st = pm_pkg::ST_ACTIVE;
          d.resume = 1'b1;
        end
      end
      pm_pkg::ST_PDOWN: begin
        if (q.cnt == 8'h01) begin
          d.st = pm_pkg::ST_SLEEP;
          d.mode = pm_pkg::SM_NONE;
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      pm_pkg::ST_SLEEP: begin
        // Wakeup clears field, starts power-up
        if (wake) begin
          d.st = pm_pkg::ST_PUP;
          d.mode = pm_pkg::SM_NONE;
          d.cnt = is_deep(q.kind) ? PU_DEEP : PU_LIGHT;
        end
      end
      pm_pkg::ST_PUP: begin
        if (q.cnt == 8'h01) begin
          d.st = pm_pkg::ST_ACTIVE;
          d.resume = 1'b1;
          d.io_hold = 1'b0;
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      default: begin
        d.st = pm_pkg::ST_ACTIVE;
      end
    endcase

    sleeping = (d.st == pm_pkg::ST_SLEEP);
    // Active keeps a fast and a slow oscillator
    if (d.st == pm_pkg::ST_PUP) begin
      d.pwr.crystal_en = q.xtal_was;
      d.pwr.fastrc_en = q.frc_was || !CRYSTAL_READY;
    end else begin
      d.pwr.crystal_en = !sleeping && !d.osc_sel;
      d.pwr.fastrc_en = !sleeping && (d.osc_sel || !CRYSTAL_READY);
    end
    // Light sleep: only fast oscillators off
    // Deep sleep: regulator off, slow osc on
    d.pwr.core_reg_en = !(sleeping && is_deep(q.kind));
    d.pwr.lsosc_en = !(sleeping && (q.kind == pm_pkg::SM_OFF));
    d.pwr.cpu_clk_en = (d.st == pm_pkg::ST_ACTIVE);
    // Fast RC clocks system until crystal stable
    d.pwr.sysclk_crystal = d.pwr.crystal_en && !d.osc_sel &&
                           CRYSTAL_READY;
    // Block wake interrupts while field nonzero
    d.irq_block = (d.mode != pm_pkg::SM_NONE);
    d.usb_rst = !d.usb_en;
    // Pins frozen from power-down to end of power-up
    if (!d.io_hold) begin
      d.io_dir = IO_DIR_CORE;
      d.io_out = IO_OUT_CORE;
    end

    if (REG_REQ.rd) begin
      case (REG_REQ.addr)
        `PM_OFS_PMC: d.rdata = 8'h00;
        `PM_OFS_SLEEP: begin
          d.rdata[`PM_MODE_MSB:`PM_MODE_LSB] = q.mode;
          d.rdata[`PM_FRC_STB_BIT] = q.pwr.fastrc_en && FASTRC_READY;
          d.rdata[`PM_XTAL_STB_BIT] = q.pwr.crystal_en && CRYSTAL_READY;
          d.rdata[`PM_USB_BIT] = q.usb_en;
        end
        `PM_OFS_CLK: begin
          d.rdata[`PM_OSC_BIT] = q.osc_sel;
          d.rdata[`PM_LSOSC_BIT] = q.lsosc_sel;
        end
        `PM_OFS_STAT: d.rdata[2:0] = q.st;
        default: d.rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  // Only RESETN reinitialises; sleep keeps values except mode field and USB bit
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      q <= '0;
      q.st <= pm_pkg::ST_ACTIVE;
      q.mode <= pm_pkg::SM_NONE;
      q.kind <= pm_pkg::SM_NONE;
      q.usb_en <= `PM_USB_RST;
      q.usb_rst <= !`PM_USB_RST;
      q.osc_sel <= `PM_OSC_RST;
      q.lsosc_sel <= `PM_LSOSC_RST;
      q.pwr.fastrc_en <= 1'b1;
      q.pwr.lsosc_en <= 1'b1;
      q.pwr.core_reg_en <= 1'b1;
      q.pwr.cpu_clk_en <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign RDATA = q.rdata;
  assign IO_DIR = q.io_dir;
  assign IO_OUT = q.io_out;
  assign IO_HOLD = q.io_hold;
  assign CPU_CLK_EN = q.pwr.cpu_clk_en;
  assign CRYSTAL_EN = q.pwr.crystal_en;
  assign FASTRC_EN = q.pwr.fastrc_en;
  assign LSOSC_EN = q.pwr.lsosc_en;
  assign CORE_REG_EN = q.pwr.core_reg_en;
  assign SYSCLK_CRYSTAL = q.pwr.sysclk_crystal;
  assign USB_RST = q.usb_rst;
  assign IRQ_BLOCK = q.irq_block;
  assign RESUME = q.resume;
  assign POWER_STATE = q.st;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);

  sequence s_enter_sleep;
    q.st == pm_pkg::ST_PDOWN ##[1:PD_MAXI] q.st == pm_pkg::ST_SLEEP;
  endsequence

  chk_idle_reads_zero: assert property (
    REG_REQ.rd && REG_REQ.addr == `PM_OFS_PMC |=> RDATA == 8'h00)
    else $error("idle trigger read nonzero");
  chk_idle_gates_cpu: assert property (
    q.st == pm_pkg::ST_IDLE |-> !CPU_CLK_EN && CORE_REG_EN)
    else $error("cpu clock running in idle");
  chk_idle_wake: assert property (
    q.st == pm_pkg::ST_IDLE && ANY_IRQ |=> CPU_CLK_EN && RESUME)
    else $error("idle not left on interrupt");
  chk_light_osc_off: assert property (
    q.st == pm_pkg::ST_SLEEP && q.kind == pm_pkg::SM_LIGHT |->
    !CRYSTAL_EN && !FASTRC_EN && CORE_REG_EN && LSOSC_EN)
    else $error("light sleep power state wrong");
  chk_deep_reg_off: assert property (
    q.st == pm_pkg::ST_SLEEP && q.kind == pm_pkg::SM_DEEP |->
    !CORE_REG_EN && LSOSC_EN)
    else $error("deep sleep power state wrong");
  chk_off_no_timer: assert property (
    q.st == pm_pkg::ST_SLEEP && q.kind == pm_pkg::SM_OFF && !EXT_IRQ
    |=> q.st == pm_pkg::ST_SLEEP && !LSOSC_EN)
    else $error("off mode left without port interrupt");
  chk_io_hold: assert property (
    IO_HOLD && $past(IO_HOLD) |-> $stable(IO_DIR) && $stable(IO_OUT))
    else $error("pins changed while held");
  chk_pdown_ends: assert property (
    $rose(q.st == pm_pkg::ST_PDOWN) |-> s_enter_sleep)
    else $error("power-down sequence did not finish");
  chk_pup_ends: assert property (
    $rose(q.st == pm_pkg::ST_PUP) |->
    ##[1:PU_MAXI] (q.st == pm_pkg::ST_ACTIVE && RESUME))
    else $error("power-up did not resume");
  chk_usb_drop: assert property (
    $rose(q.st == pm_pkg::ST_PDOWN) && q.kind != pm_pkg::SM_LIGHT
    |-> USB_RST)
    else $error("usb kept into deep sleep");
  chk_sysclk_fallback: assert property (
    !$past(CRYSTAL_READY) |-> !SYSCLK_CRYSTAL)
    else $error("crystal used before stable");
  chk_wake_clears: assert property (
    q.st == pm_pkg::ST_SLEEP && EXT_IRQ |=>
    q.st == pm_pkg::ST_PUP && q.mode == pm_pkg::SM_NONE)
    else $error("wake did not clear mode");
  chk_mode_block: assert property (
    q.mode != pm_pkg::SM_NONE |-> IRQ_BLOCK)
    else $error("interrupts not blocked");
  chk_entry_clears: assert property (
    $rose(q.st == pm_pkg::ST_SLEEP) |->
    q.mode == pm_pkg::SM_NONE && !IRQ_BLOCK)
    else $error("mode field not cleared at entry");

endmodule : power_mode_controller

// >>> tb/testbench.sv
// Self-checking bench for the power mode controller
`timescale 1ns/1ps
`include "pm_defines.svh"

module testbench;
  logic REF_CLK;
  logic RESETN;
  pm_pkg::reg_req_t REG_REQ;
  logic [7:0] RDATA, IO_DIR, IO_OUT, IO_DIR_CORE, IO_OUT_CORE;
  logic EXT_IRQ, TIMER_IRQ, ANY_IRQ, CRYSTAL_READY, FASTRC_READY;
  logic IO_HOLD, CPU_CLK_EN, CRYSTAL_EN, FASTRC_EN, LSOSC_EN;
  logic CORE_REG_EN, SYSCLK_CRYSTAL, USB_RST, IRQ_BLOCK, RESUME;
  logic [2:0] POWER_STATE;
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;

  power_mode_controller u_power_mode_controller (
    .REF_CLK(REF_CLK), .RESETN(RESETN), .REG_REQ(REG_REQ),
    .RDATA(RDATA), .EXT_IRQ(EXT_IRQ), .TIMER_IRQ(TIMER_IRQ),
    .ANY_IRQ(ANY_IRQ), .CRYSTAL_READY(CRYSTAL_READY),
    .FASTRC_READY(FASTRC_READY), .IO_DIR_CORE(IO_DIR_CORE),
    .IO_OUT_CORE(IO_OUT_CORE), .IO_DIR(IO_DIR), .IO_OUT(IO_OUT),
    .IO_HOLD(IO_HOLD), .CPU_CLK_EN(CPU_CLK_EN), .CRYSTAL_EN(CRYSTAL_EN),
    .FASTRC_EN(FASTRC_EN), .LSOSC_EN(LSOSC_EN), .CORE_REG_EN(CORE_REG_EN),
    .SYSCLK_CRYSTAL(SYSCLK_CRYSTAL), .USB_RST(USB_RST),
    .IRQ_BLOCK(IRQ_BLOCK), .RESUME(RESUME), .POWER_STATE(POWER_STATE)
  );

  initial begin
    REF_CLK = 1'b0;
    forever #12.5 REF_CLK = ~REF_CLK;
  end

  ////////////////////////////////////////////////////////////////////////
  task complete_run;
    $display("mismatches %0d, comparisons %0d", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  task check_val(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : check_val

  task reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge REF_CLK);
    REG_REQ <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge REF_CLK);
    REG_REQ.wr <= 1'b0;
    #1;
  endtask : reg_write

  task reg_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge REF_CLK);
    REG_REQ <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge REF_CLK);
    REG_REQ.rd <= 1'b0;
    #1;
    d = RDATA;
  endtask : reg_read

  task pulse(input int which);
    @(posedge REF_CLK);
    if (which == 0) EXT_IRQ <= 1'b1;
    else if (which == 1) TIMER_IRQ <= 1'b1;
    else ANY_IRQ <= 1'b1;
    @(posedge REF_CLK);
    {EXT_IRQ, TIMER_IRQ, ANY_IRQ} <= 3'b000;
    #1;
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////
  task test_reset_values;
    logic [7:0] d;
    check_val({5'h00, POWER_STATE}, 8'h00);
    check_val({CPU_CLK_EN, CORE_REG_EN}, 8'h03);
    check_val({FASTRC_EN, CRYSTAL_EN}, 8'h02);
    check_val({USB_RST, LSOSC_EN}, 8'h03);
    reg_read(4'h1, d);
    check_val(d, 8'h20);
    reg_read(4'h2, d);
    check_val(d, 8'h01);
    reg_read(4'h9, d);
    check_val(d, 8'h00);
  endtask : test_reset_values

  task test_idle;
    logic [7:0] d;
    reg_write(4'h0, 8'h01);
    check_val({5'h00, POWER_STATE}, 8'h01);
    check_val({CPU_CLK_EN, FASTRC_EN, CORE_REG_EN}, 8'h03);
    reg_read(4'h0, d);
    check_val(d, 8'h00);
    pulse(2);
    check_val({POWER_STATE, RESUME, CPU_CLK_EN}, 8'h03);
  endtask : test_idle

  task run_sleep(input logic [1:0] m, input logic [7:0] pd,
                 input logic [7:0] pu, input logic [7:0] pwr_exp,
                 input logic timer_wake);
    logic [7:0] d;
    IO_DIR_CORE <= 8'hA5;
    IO_OUT_CORE <= 8'h3C;
    reg_write(4'h1, {1'b1, 5'h00, m});
    check_val({7'h00, IRQ_BLOCK}, 8'h01);
    reg_write(4'h0, 8'h01);
    check_val({5'h00, POWER_STATE}, 8'h02);
    check_val({IO_HOLD, CPU_CLK_EN, USB_RST}, {5'h00, 2'b10, m[1]});
    pulse(0);
    check_val({5'h00, POWER_STATE}, (pd > 8'h02) ? 8'h02 : 8'h03);
    repeat (pd - 8'h02) @(posedge REF_CLK);
    #1;
    check_val({5'h00, POWER_STATE}, 8'h03);
    check_val({7'h00, IRQ_BLOCK}, 8'h00);
    check_val({CRYSTAL_EN, FASTRC_EN}, 8'h00);
    check_val({CORE_REG_EN, LSOSC_EN}, pwr_exp);
    IO_DIR_CORE <= 8'h00;
    IO_OUT_CORE <= 8'hFF;
    pulse(1);
    if (!timer_wake) begin
      check_val({5'h00, POWER_STATE}, 8'h03);
      pulse(0);
    end
    check_val(IO_DIR, 8'hA5);
    check_val(IO_OUT, 8'h3C);
    check_val({5'h00, POWER_STATE}, 8'h04);
    repeat (pu) @(posedge REF_CLK);
    #1;
    check_val({POWER_STATE, RESUME, IO_HOLD, CPU_CLK_EN}, 8'h05);
    check_val({FASTRC_EN, CORE_REG_EN, LSOSC_EN}, 8'h07);
    // Mode field reads zero after wake, clock register kept
    reg_read(4'h1, d);
    check_val(d & 8'h03, 8'h00);
    reg_read(4'h2, d);
    check_val(d, 8'h01);
  endtask : run_sleep

  task test_crystal;
    logic [7:0] d;
    reg_write(`PM_OFS_CLK, 8'h80);
    check_val({CRYSTAL_EN, FASTRC_EN, SYSCLK_CRYSTAL}, 8'h05);
    reg_read(`PM_OFS_CLK, d);
    check_val(d, 8'h80);
    @(posedge REF_CLK);
    CRYSTAL_READY <= 1'b0;
    @(posedge REF_CLK);
    #1;
    check_val({CRYSTAL_EN, FASTRC_EN, SYSCLK_CRYSTAL}, 8'h06);
    reg_read(`PM_OFS_SLEEP, d);
    check_val(d, 8'h20);
    @(posedge REF_CLK);
    CRYSTAL_READY <= 1'b1;
    reg_read(`PM_OFS_SLEEP, d);
    check_val(d, 8'h40);
    // Handler clears an armed mode field
    reg_write(`PM_OFS_SLEEP, 8'h01);
    check_val({7'h00, IRQ_BLOCK}, 8'h01);
    reg_write(`PM_OFS_SLEEP, 8'h00);
    check_val({IRQ_BLOCK, POWER_STATE}, 8'h00);
  endtask : test_crystal

  task test_reset_wake;
    logic [7:0] d;
    reg_write(`PM_OFS_SLEEP, 8'h03);
    reg_write(`PM_OFS_PMC, 8'h01);
    repeat (`PM_PD_DEEP_CYC) @(posedge REF_CLK);
    #1;
    check_val({5'h00, POWER_STATE}, 8'h03);
    @(posedge REF_CLK);
    RESETN <= 1'b0;
    @(posedge REF_CLK);
    #1;
    check_val({5'h00, POWER_STATE}, 8'h00);
    check_val({CPU_CLK_EN, CORE_REG_EN, LSOSC_EN, IO_HOLD}, 8'h0E);
    @(posedge REF_CLK);
    RESETN <= 1'b1;
    reg_read(`PM_OFS_SLEEP, d);
    check_val(d, 8'h20);
  endtask : test_reset_wake

  ////////////////////////////////////////////////////////////////////////
  always @(posedge REF_CLK) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      complete_run;
    end
  end

  initial begin
    RESETN = 1'b0;
    REG_REQ = '0;
    {EXT_IRQ, TIMER_IRQ, ANY_IRQ} = 3'b000;
    CRYSTAL_READY = 1'b1;
    FASTRC_READY = 1'b1;
    IO_DIR_CORE = 8'h00;
    IO_OUT_CORE = 8'h00;
    repeat (4) @(posedge REF_CLK);
    RESETN <= 1'b1;
    @(posedge REF_CLK);
    #1;
    test_reset_values;
    test_idle;
    run_sleep(2'b01, `PM_PD_LIGHT_CYC, `PM_PU_LIGHT_CYC, 8'h03, 1'b1);
    run_sleep(2'b10, `PM_PD_DEEP_CYC, `PM_PU_DEEP_CYC, 8'h01, 1'b1);
    run_sleep(2'b11, `PM_PD_DEEP_CYC, `PM_PU_DEEP_CYC, 8'h00, 1'b0);
    test_crystal;
    test_reset_wake;
    complete_run;
  end
endmodule : testbench
